// file: src/rtss_pkg.sv
// package for the remote terminal system status register
package rtss_pkg;

  // status word bit positions
  localparam int FIELD_LSB      = 0;
  localparam int FIELD_MSB      = 4;
  localparam int MODE_SUB_BIT   = 5;
  localparam int CHAN_A_BIT     = 6;
  localparam int CHANNEL_B_ENABLED_BIT    = 7;
  localparam int CHANNEL_A_ENABLED_BIT    = 8;
  localparam int TFLAG_EN_BIT   = 9;
  localparam int BUSY_BIT       = 10;
  localparam int SELFTEST_BIT   = 11;
  localparam int PARITY_ERR_BIT = 12;
  localparam int MSG_ERR_BIT    = 13;
  localparam int VALID_MSG_BIT  = 14;
  localparam int TERM_ACT_BIT   = 15;

  // status word reset value
  localparam logic [15:0] STATUS_RESET = 16'h0240;

  // register address selecting the status word
  localparam logic ADDR_STATUS = 1'b0;

  // command field code of inhibit terminal flag and its override
  localparam logic [4:0] MC_INHIBIT_TFLAG  = 5'h06;
  localparam logic [4:0] MC_OVERRIDE_TFLAG = 5'h07;

  // decoded command as reported by the decoder logic
  typedef struct packed {
    logic       valid;
    logic       is_sub;
    logic       on_chan_a;
    logic [4:0] field;
  } rtss_cmd_t;

  // host register port pins; cs_n and ctrl_n active low, rd_wr high for a read
  typedef struct packed {
    logic cs_n;
    logic ctrl_n;
    logic rd_wr;
    logic addr0;
  } rtss_host_t;

endpackage : rtss_pkg

// file: src/rtss_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module rtss_sync
  import rtss_pkg::*;
#(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '1;
      q_out    <= '1;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : rtss_sync

// file: src/rtss_status.sv
// system status register of the remote terminal interface
`timescale 1ns/10ps
module rtss_status
  import rtss_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // host register port pins
  input  wire rtss_host_t  host_in,
  // decoded command from the decoders
  input  wire rtss_cmd_t   cmd_in,
  // control register state
  input  wire logic        channel_a_enabled_in,
  input  wire logic        channel_b_enabled_in,
  input  wire logic        host_busy_request_in,
  input  wire logic        self_test_in,
  // error and message events
  input  wire logic        address_parity_error_in,
  input  wire logic        message_error_in,
  input  wire logic        valid_message_in,
  // activity pins
  input  wire logic        transmit_active_n_in,
  input  wire logic        receive_active_n_in,
  // data pins
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe_out,
  // command field status pins
  output logic [4:0]       command_field_bits_out,
  output logic             mode_or_sub_flag_out
);

  logic [5:0]  pins_sync;
  logic        cs_n_s, ctrl_n_s, rd_wr_s, addr0_s, transmit_active_n_n_s, rcv_n_s;
  logic        rd_sel, rd_sel_reg;
  logic [4:0]  field_reg;
  logic        is_sub_reg;
  logic        chan_a_reg;
  logic        tflag_en_reg;
  logic        busy_reg;
  logic        msg_err_reg;
  logic        valid_msg_reg;
  logic [15:0] status_word;

  rtss_sync #(.W(6)) u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .d_in        ({host_in.cs_n, host_in.ctrl_n, host_in.rd_wr, host_in.addr0,
                   transmit_active_n_in, receive_active_n_in}),
    .q_out       (pins_sync)
  );

  assign {cs_n_s, ctrl_n_s, rd_wr_s, addr0_s, transmit_active_n_n_s, rcv_n_s} = pins_sync;

  assign rd_sel = !cs_n_s && !ctrl_n_s && rd_wr_s && (addr0_s == ADDR_STATUS);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      field_reg  <= '0;
      is_sub_reg <= 1'b0;
      chan_a_reg <= 1'b1;
    end else if (cmd_in.valid) begin
      field_reg  <= cmd_in.field;
      is_sub_reg <= cmd_in.is_sub;
      chan_a_reg <= cmd_in.on_chan_a;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tflag_en_reg <= 1'b1;
    end else if (cmd_in.valid && !cmd_in.is_sub) begin
      if (cmd_in.field == MC_INHIBIT_TFLAG) begin
        tflag_en_reg <= 1'b0;
      end else if (cmd_in.field == MC_OVERRIDE_TFLAG) begin
        tflag_en_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= host_busy_request_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      msg_err_reg <= 1'b0;
    end else if (message_error_in || address_parity_error_in) begin
      msg_err_reg <= 1'b1;
    end else if (rd_sel_reg && !rd_sel) begin
      msg_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valid_msg_reg <= 1'b0;
    end else if (valid_message_in) begin
      valid_msg_reg <= 1'b1;
    end else if (rd_sel_reg && !rd_sel) begin
      valid_msg_reg <= 1'b0;
    end
  end

  always_comb begin
    status_word                              = '0;
    status_word[FIELD_MSB:FIELD_LSB]         = field_reg;
    status_word[MODE_SUB_BIT]                = is_sub_reg;
    status_word[CHAN_A_BIT]                  = chan_a_reg;
    status_word[CHANNEL_B_ENABLED_BIT]                 = channel_b_enabled_in;
    status_word[CHANNEL_A_ENABLED_BIT]                 = channel_a_enabled_in;
    status_word[TFLAG_EN_BIT]                = tflag_en_reg;
    status_word[BUSY_BIT]                    = busy_reg;
    status_word[SELFTEST_BIT]                = self_test_in;
    status_word[PARITY_ERR_BIT]              = address_parity_error_in;
    status_word[MSG_ERR_BIT]                 = msg_err_reg;
    status_word[VALID_MSG_BIT]               = valid_msg_reg;
    status_word[TERM_ACT_BIT]                = ~(transmit_active_n_n_s & rcv_n_s);
  end

  // drive data pins during a read
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_sel_reg  <= 1'b0;
      data_out    <= '0;
      data_oe_out <= '0;
    end else begin
      rd_sel_reg  <= rd_sel;
      data_oe_out <= {16{rd_sel}};
      // hold word captured at read start
      if (rd_sel && !rd_sel_reg) begin
        data_out <= status_word;
      end else if (!rd_sel) begin
        data_out <= '0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      command_field_bits_out <= '0;
      mode_or_sub_flag_out   <= 1'b0;
    end else begin
      command_field_bits_out <= field_reg;
      mode_or_sub_flag_out   <= is_sub_reg;
    end
  end

  sequence s_read_end;
    rd_sel_reg && !rd_sel;
  endsequence : s_read_end

  a_valid_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_read_end ##0 !valid_message_in |=> !valid_msg_reg)
    else $error("valid flag not cleared after read");

  a_err_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_read_end ##0 !message_error_in && !address_parity_error_in |=> !msg_err_reg)
    else $error("message error not cleared after read");

  a_err_set: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    message_error_in |=> msg_err_reg)
    else $error("message error not set");

  a_read_keeps: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    rd_sel && !rd_sel_reg && valid_msg_reg |=> data_out[VALID_MSG_BIT])
    else $error("read lost valid flag");

  a_oe_sel: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    rd_sel |=> data_oe_out == 16'hffff)
    else $error("data not driven during read");

  a_tflag_inh: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    cmd_in.valid && !cmd_in.is_sub && cmd_in.field == MC_INHIBIT_TFLAG |=> !tflag_en_reg)
    else $error("terminal flag not inhibited");

  a_chan_latch: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    cmd_in.valid |=> chan_a_reg == $past(cmd_in.on_chan_a))
    else $error("channel not latched");

  a_busy_track: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !host_busy_request_in |=> !busy_reg)
    else $error("busy not cleared");

  a_pin_mirror: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    cmd_in.valid |=> ##1 command_field_bits_out == $past(cmd_in.field, 2))
    else $error("pins do not mirror field");

endmodule : rtss_status

// file: bench/rtss_host_model.sv
// host processor model reading the status register
`timescale 1ns/10ps
module rtss_host_model
  import rtss_pkg::*;
(
  // clock
  input  wire logic        core_clk_in,
  // host pins and data bus
  output rtss_host_t       host_out,
  input  wire logic [15:0] data_in,
  input  wire logic [15:0] data_oe_in
);
  // pins idle high between accesses
  initial host_out = 4'hf;

  // read strobes held until data seen, for at most 8 cycles
  task automatic rd(input logic a0, output logic [15:0] w, output logic ok);
    ok = 1'b0;
    w = 16'h0000;
    @(posedge core_clk_in);
    #1 host_out = '{cs_n: 1'b0, ctrl_n: 1'b0, rd_wr: 1'b1, addr0: a0};
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge core_clk_in);
      #1;
      if (data_oe_in === 16'hffff) begin
        ok = 1'b1;
        w = data_in;
      end
    end
    host_out = 4'hf;
    repeat (4) @(posedge core_clk_in);
  endtask : rd
endmodule : rtss_host_model

// file: bench/rtss_status_tb.sv
// testbench for the system status register
`timescale 1ns/10ps
module rtss_status_tb
  import rtss_pkg::*;
;
  typedef struct packed {
    logic sub; logic ona; logic [4:0] fld; logic [3:0] lv; logic [1:0] act_n; logic [15:0] exp;
  } rtss_row_t;
  localparam rtss_row_t ROWS [3] = '{'{1'b1, 1'b1, 5'h15, 4'h8, 2'b01, 16'h8375},
                                    '{1'b0, 1'b0, 5'h06, 4'h7, 2'b11, 16'h0c86},
                                    '{1'b0, 1'b1, 5'h07, 4'hc, 2'b10, 16'h83c7}};
  localparam logic [15:0] B = 16'h83c7;
  logic core_clk_in, rstn_in, cha, chb, busy, st, perr, merr, vmsg, tx_n, rx_n, mos;
  rtss_host_t host;
  rtss_cmd_t cmd;
  logic [15:0] data, oe, w;
  logic [4:0] fld;
  int n_fail = 0;
  int checked = 0;

  rtss_status dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .host_in(host), .cmd_in(cmd),
    .channel_a_enabled_in(cha), .channel_b_enabled_in(chb), .host_busy_request_in(busy),
    .self_test_in(st), .address_parity_error_in(perr), .message_error_in(merr),
    .valid_message_in(vmsg), .transmit_active_n_in(tx_n), .receive_active_n_in(rx_n),
    .data_out(data), .data_oe_out(oe), .command_field_bits_out(fld),
    .mode_or_sub_flag_out(mos));
  rtss_host_model host_m (.core_clk_in(core_clk_in), .host_out(host), .data_in(data),
    .data_oe_in(oe));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic rd(input logic a0, input logic eok, input logic [15:0] e);
    logic ok;
    logic [15:0] v;
    host_m.rd(a0, v, ok);
    chk({15'h0000, ok}, {15'h0000, eok});
    if (ok !== eok) end_sim();
    if (eok) chk(v, e);
    chk(oe | data, 16'h0000);
  endtask : rd

  task automatic pulse;
    @(posedge core_clk_in);
    #1 vmsg = 1'b1;
    @(posedge core_clk_in);
    #1 vmsg = 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask : pulse

  initial begin
    rstn_in = 1'b0;
    cmd = '0;
    {cha, chb, busy, st, perr, merr, vmsg} = 7'h00;
    {tx_n, rx_n} = 2'b11;
    repeat (10) @(posedge core_clk_in);
    chk(oe | data, 16'h0000);
    #1 rstn_in = 1'b1;
    rd(1'b0, 1'b1, STATUS_RESET);
    $display("reset test done");
    foreach (ROWS[i]) begin
      @(posedge core_clk_in);
      #1 cmd = '{1'b1, ROWS[i].sub, ROWS[i].ona, ROWS[i].fld};
      {cha, chb, busy, st} = ROWS[i].lv;
      {tx_n, rx_n} = ROWS[i].act_n;
      @(posedge core_clk_in);
      #1 cmd.valid = 1'b0;
      repeat (4) @(posedge core_clk_in);
      rd(1'b0, 1'b1, ROWS[i].exp);
      chk({10'h000, mos, fld}, {10'h000, ROWS[i].exp[5:0]});
      $display("row %0d done", i);
    end
    pulse();
    rd(1'b0, 1'b1, B | 16'h4000);
    rd(1'b0, 1'b1, B);
    pulse();
    rd(1'b1, 1'b0, B);
    rd(1'b0, 1'b1, B | 16'h4000);
    rd(1'b0, 1'b1, B);
    $display("valid message test done");
    #1 merr = 1'b1;
    rd(1'b0, 1'b1, B | 16'h2000);
    rd(1'b0, 1'b1, B | 16'h2000);
    #1 merr = 1'b0;
    rd(1'b0, 1'b1, B | 16'h2000);
    rd(1'b0, 1'b1, B);
    $display("message error test done");
    #1 perr = 1'b1;
    rd(1'b0, 1'b1, B | 16'h3000);
    #1 perr = 1'b0;
    rd(1'b0, 1'b1, B | 16'h2000);
    rd(1'b0, 1'b1, B);
    $display("parity error test done");
    #1 cmd = '{1'b1, 1'b0, 1'b0, MC_INHIBIT_TFLAG};
    vmsg = 1'b1;
    @(posedge core_clk_in);
    #1 cmd.valid = 1'b0;
    vmsg = 1'b0;
    {cha, chb, tx_n, rx_n} = 4'h3;
    rstn_in = 1'b0;
    #1 chk(oe | data, 16'h0000);
    chk({10'h000, mos, fld}, 16'h0000);
    repeat (10) @(posedge core_clk_in);
    #1 rstn_in = 1'b1;
    rd(1'b0, 1'b1, STATUS_RESET);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : rtss_status_tb
